// ===== src/epi_async_edge.v
// Purpose: Clockless edge catcher for pin two
// Assumes: Pin edge clocks a flop; clear is a level from hclk domain
// Notes: Polarity picked by xnor, so changing the sense can itself fire
`timescale 1ns/1ps
module epi_async_edge (
   input wire pin,
   input wire rise_sel,
   input wire clr,
   input wire hresetn,
   output reg caught
);
   wire edge_clk;
   wire clr_n;

   // Rising edge when selected, else falling edge; no clock involved
   assign edge_clk = pin ~^ rise_sel;
   assign clr_n = hresetn & ~clr;

   always @(posedge edge_clk or negedge clr_n) begin
      if (!clr_n) begin
         caught <= 1'b0;
      end else begin
         caught <= 1'b1;
      end
   end
endmodule

// ===== src/epi_defs.vh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: Included by the top design file of the block and by the tests
`ifndef EPI_DEFS_VH
`define EPI_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define EPI_OFS_SENSE 8'h00
`define EPI_OFS_CSR 8'h04
`define EPI_OFS_ENABLE 8'h08
`define EPI_OFS_FLAGS 8'h0C
`define EPI_OFS_CORE 8'h10
`define EPI_OFS_PINDIR 8'h14
`define EPI_OFS_VECTOR 8'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define EPI_SENSE_ZERO_LO 0
`define EPI_SENSE_ONE_LO 2
`define EPI_SENSE_TWO_BIT 6
`define EPI_PIN_ONE_BIT 7
`define EPI_PIN_ZERO_BIT 6
`define EPI_PIN_TWO_BIT 5
`define EPI_CORE_GIE_BIT 7
`define EPI_CORE_SLEEP_BIT 0

// ------------------------------------------------------------
// Sense encodings and reset values
// ------------------------------------------------------------
`define EPI_MODE_LOW 2'b00
`define EPI_MODE_ANY 2'b01
`define EPI_MODE_FALL 2'b10
`define EPI_MODE_RISE 2'b11
`define EPI_RST_SENSE 8'h00
`define EPI_RST_CSR 8'h00
`define EPI_RST_ENABLE 8'h00
`define EPI_RST_CORE 8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define EPI_CLK_NS 20
`define EPI_MIN_PULSE_NS 50
`define EPI_WDOG_PERIOD_NS 1000
`define EPI_WDOG_DIV ((`EPI_WDOG_PERIOD_NS) / (`EPI_CLK_NS))
`define EPI_STARTUP_CYCLES 64

`endif

// ===== src/epi_sync3.v
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input from outside the hclk domain
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
module epi_sync3 (
   input wire hclk,
   input wire hresetn,
   input wire din,
   output reg dout
);
   reg s1;
   reg s2;
   reg s3;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule

// ===== src/epi_top.v
// Purpose: External pin interrupt controller behind an AHB-Lite slave
// Assumes: hclk 50 MHz is the I/O clock; it is gated off in deep sleep
// Notes: Register data sits in the low byte of each word
// Overview of operation
// - Pin one sense bits 3:2 select mode
// - Pin zero sense bits 1:0 same encoding
// - Pin two bit 6 picks fall or rise
// - Pin two edges caught without clock
// - Requests raised even when pin drives out
// - Low level keeps requesting while low
// - Edge modes sample pins with I/O clock
// - Level and pin-two detection clockless
// - Clocked edge detect off in deep sleep
// - Level wake needs two watchdog samples
// - Level gone before start-up: wake, no interrupt
// - Request needs global and pin enable
// - Qualifying event sets the pin flag
// - Flag clears on vector or write one
// - Level-mode flags always read zero
// - Each pin has its own vector
// - Buffer off in sleep may set flag
// - Sense control register resets to zero
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "epi_defs.vh"
module epi_top #(
   parameter STARTUP_CYCLES = `EPI_STARTUP_CYCLES
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire ext_irq_pin_zero,
   input wire ext_irq_pin_one,
   input wire ext_irq_pin_two,
   input wire vector_ack,
   input wire [1:0] vector_ack_id,
   output reg irq_req,
   output reg [1:0] irq_vector,
   output reg wake_req
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [7:0] mcu_sense_control;
   reg [7:0] mcu_control_status;
   reg [7:0] pin_interrupt_enable;
   reg [7:0] core_status_word;
   reg [2:0] pin_dir;
   reg pin_zero_flag;
   reg pin_one_flag;
   reg pin_two_flag;

   // ------------------------------------------------------------
   // Bus address phase capture
   // ------------------------------------------------------------
   reg wr_pend;
   reg [7:0] wr_addr;
   wire take = hsel & hready & htrans[1];
   wire wr_go = wr_pend;
   wire [7:0] wd = hwdata[7:0];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= take & hwrite;
         if (take) begin
            wr_addr <= haddr[7:0];
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------
   wire p0_s;
   wire p1_s;
   wire [1:0] pins01 = {ext_irq_pin_one, ext_irq_pin_zero};
   wire [1:0] pins_s;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         epi_sync3 u_sync (
            .hclk(hclk),
            .hresetn(hresetn),
            .din(pins01[gi]),
            .dout(pins_s[gi])
         );
      end
   endgenerate
   assign p0_s = pins_s[0];
   assign p1_s = pins_s[1];

   reg p0_prev;
   reg p1_prev;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p0_prev <= 1'b1;
         p1_prev <= 1'b1;
      end else begin
         p0_prev <= p0_s;
         p1_prev <= p1_s;
      end
   end

   wire [1:0] mode1 = mcu_sense_control[`EPI_SENSE_ONE_LO+1:`EPI_SENSE_ONE_LO];
   wire [1:0] mode0 = mcu_sense_control[`EPI_SENSE_ZERO_LO+1:`EPI_SENSE_ZERO_LO];

   function edge_hit;
      input [1:0] mode;
      input cur;
      input prev;
      begin
         case (mode)
            `EPI_MODE_ANY: edge_hit = cur ^ prev;
            `EPI_MODE_FALL: edge_hit = prev & ~cur;
            `EPI_MODE_RISE: edge_hit = cur & ~prev;
            default: edge_hit = 1'b0;
         endcase
      end
   endfunction

   // no clocked edges while asleep (clock would be gated)
   wire sleeping = core_status_word[`EPI_CORE_SLEEP_BIT];
   // pin direction has no influence on detection
   wire hit0 = edge_hit(mode0, p0_s, p0_prev) & ~sleeping;
   wire hit1 = edge_hit(mode1, p1_s, p1_prev) & ~sleeping;

   // level request tracks the raw pin, clockless
   wire lvl0 = (mode0 == `EPI_MODE_LOW) & ~ext_irq_pin_zero;
   wire lvl1 = (mode1 == `EPI_MODE_LOW) & ~ext_irq_pin_one;

   // ------------------------------------------------------------
   // Pin two asynchronous capture
   // ------------------------------------------------------------
   wire two_caught;
   reg two_clr;
   wire two_sync;
   // buffer gated when sleeping and disabled
   wire two_en = pin_interrupt_enable[`EPI_PIN_TWO_BIT];
   wire two_pin = (sleeping & ~two_en) ? 1'b0 : ext_irq_pin_two;
   epi_async_edge u_two (
      .pin(two_pin),
      .rise_sel(mcu_control_status[`EPI_SENSE_TWO_BIT]),
      .clr(two_clr),
      .hresetn(hresetn),
      .caught(two_caught)
   );
   epi_sync3 u_two_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .din(~two_caught),
      .dout(two_sync)
   );
   reg two_seen;
   wire hit2 = ~two_sync & ~two_seen & ~two_clr;

   // ------------------------------------------------------------
   // Wake from power-down on level
   // ------------------------------------------------------------
   reg [5:0] wd_cnt;
   reg wd_tick;
   reg [1:0] lvl_samp;
   reg [7:0] start_cnt;
   reg starting;
   reg lvl_missed;
   wire lvl_any = (lvl0 & pin_interrupt_enable[`EPI_PIN_ZERO_BIT])
      | (lvl1 & pin_interrupt_enable[`EPI_PIN_ONE_BIT]);
   localparam [31:0] WD_LAST = `EPI_WDOG_DIV - 1;
   localparam [31:0] START_LOAD = STARTUP_CYCLES;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wd_cnt <= 6'h00;
         wd_tick <= 1'b0;
         lvl_samp <= 2'b00;
         start_cnt <= 8'h00;
         starting <= 1'b0;
         lvl_missed <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         wd_tick <= 1'b0;
         if (wd_cnt == WD_LAST[5:0]) begin
            wd_cnt <= 6'h00;
            wd_tick <= 1'b1;
         end else begin
            wd_cnt <= wd_cnt + 6'h01;
         end
         if (wd_tick & sleeping & ~starting) begin
            lvl_samp <= lvl_any ? {lvl_samp[0], 1'b1} : 2'b00;
         end
         wake_req <= 1'b0;
         if (lvl_samp == 2'b11 & ~starting) begin
            starting <= 1'b1;
            start_cnt <= START_LOAD[7:0];
            wake_req <= 1'b1;
            lvl_samp <= 2'b00;
            lvl_missed <= 1'b0;
         end else if (starting) begin
            if (~lvl_any) begin
               lvl_missed <= 1'b1;
            end
            if (start_cnt == 8'h00) begin
               starting <= 1'b0;
            end else begin
               start_cnt <= start_cnt - 8'h01;
            end
         end else if (~sleeping) begin
            lvl_missed <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Register writes and flags
   // ------------------------------------------------------------
   wire w_sense = wr_go & (wr_addr == `EPI_OFS_SENSE);
   wire w_csr = wr_go & (wr_addr == `EPI_OFS_CSR);
   wire w_en = wr_go & (wr_addr == `EPI_OFS_ENABLE);
   wire w_flag = wr_go & (wr_addr == `EPI_OFS_FLAGS);
   wire w_core = wr_go & (wr_addr == `EPI_OFS_CORE);
   wire w_dir = wr_go & (wr_addr == `EPI_OFS_PINDIR);
   // vector entry clears its own flag
   wire ack0 = vector_ack & (vector_ack_id == 2'd0);
   wire ack1 = vector_ack & (vector_ack_id == 2'd1);
   wire ack2 = vector_ack & (vector_ack_id == 2'd2);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mcu_sense_control <= `EPI_RST_SENSE;
         mcu_control_status <= `EPI_RST_CSR;
         pin_interrupt_enable <= `EPI_RST_ENABLE;
         core_status_word <= `EPI_RST_CORE;
         pin_dir <= 3'b000;
         pin_zero_flag <= 1'b0;
         pin_one_flag <= 1'b0;
         pin_two_flag <= 1'b0;
         two_clr <= 1'b0;
         two_seen <= 1'b0;
      end else begin
         if (w_sense) begin
            mcu_sense_control <= wd;
         end
         if (w_csr) begin
            mcu_control_status <= wd;
         end
         if (w_en) begin
            pin_interrupt_enable <= wd & 8'hE0;
         end
         if (w_core) begin
            core_status_word <= wd;
         end
         if (w_dir) begin
            pin_dir <= wd[2:0];
         end
         // event sets flag, set wins over clear
         if (mode0 == `EPI_MODE_LOW) begin
            pin_zero_flag <= 1'b0;
         end else if (hit0) begin
            pin_zero_flag <= 1'b1;
         end else if ((w_flag & wd[`EPI_PIN_ZERO_BIT]) | ack0) begin
            pin_zero_flag <= 1'b0;
         end
         if (mode1 == `EPI_MODE_LOW) begin
            pin_one_flag <= 1'b0;
         end else if (hit1) begin
            pin_one_flag <= 1'b1;
         end else if ((w_flag & wd[`EPI_PIN_ONE_BIT]) | ack1) begin
            pin_one_flag <= 1'b0;
         end
         if (hit2) begin
            pin_two_flag <= 1'b1;
            two_seen <= 1'b1;
            two_clr <= 1'b1;
         end else if ((w_flag & wd[`EPI_PIN_TWO_BIT]) | ack2) begin
            pin_two_flag <= 1'b0;
         end
         // Hold the catcher clear until its sync path reads idle again
         if (two_clr & two_sync) begin
            two_clr <= 1'b0;
            two_seen <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Request and vector
   // ------------------------------------------------------------
   // global and pin enable gate
   wire gie = core_status_word[`EPI_CORE_GIE_BIT];
   wire req0 = gie & pin_interrupt_enable[`EPI_PIN_ZERO_BIT]
      & (pin_zero_flag | (lvl0 & ~lvl_missed));
   wire req1 = gie & pin_interrupt_enable[`EPI_PIN_ONE_BIT]
      & (pin_one_flag | (lvl1 & ~lvl_missed));
   wire req2 = gie & two_en & pin_two_flag;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_req <= 1'b0;
         irq_vector <= 2'd0;
      end else begin
         irq_req <= req0 | req1 | req2;
         if (req0) begin
            irq_vector <= 2'd0;
         end else if (req1) begin
            irq_vector <= 2'd1;
         end else if (req2) begin
            irq_vector <= 2'd2;
         end
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   reg [7:0] rd;
   always @* begin
      case (haddr[7:0])
         `EPI_OFS_SENSE: rd = mcu_sense_control;
         `EPI_OFS_CSR: rd = mcu_control_status;
         `EPI_OFS_ENABLE: rd = pin_interrupt_enable;
         `EPI_OFS_FLAGS: rd = {pin_one_flag, pin_zero_flag, pin_two_flag, 5'h00};
         `EPI_OFS_CORE: rd = core_status_word;
         `EPI_OFS_PINDIR: rd = {5'h00, pin_dir};
         `EPI_OFS_VECTOR: rd = {irq_req, 5'h00, irq_vector};
         default: rd = 8'h00;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take & ~hwrite) begin
         hrdata <= {24'h00_0000, rd};
      end
   end
endmodule

// ===== test/epi_pin_src.sv
// Purpose: External sources that drive the three interrupt pins
// Assumes: Pins change away from the clock edge, as real sources do
// Notes: The pins have no pull; each level is held until it is changed
`timescale 1ns/1ps
module epi_pin_src (
   input wire logic hclk,
   output logic [2:0] pins
);
   initial pins = 3'h7;

   task automatic put(input int i, input logic v);
      @(posedge hclk);
      #3;
      pins[i] = v;
   endtask

   task automatic pulse2();
      @(posedge hclk);
      #7;
      pins[2] = ~pins[2];
      #60;
      pins[2] = ~pins[2];
   endtask
endmodule

// ===== test/epi_top_properties.sv
// Purpose: Port-level checks of the pin interrupt block
// Assumes: Register writes are shadowed from the bus traffic
// Notes: Sleep masks the shadowed arm terms, so the edge and level checks skip deep sleep
`timescale 1ns/1ps
`include "epi_defs.vh"
module epi_top_checker #(
   parameter STARTUP_CYCLES = 64
) (
   input logic hclk,
   input logic hresetn,
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic [31:0] hwdata,
   input logic hready,
   input logic [31:0] hrdata,
   input logic hreadyout,
   input logic hresp,
   input logic ext_irq_pin_zero,
   input logic ext_irq_pin_one,
   input logic ext_irq_pin_two,
   input logic vector_ack,
   input logic [1:0] vector_ack_id,
   input logic irq_req,
   input logic [1:0] irq_vector,
   input logic wake_req
);
   logic ph;
   logic [7:0] pa, sense_s, en_s, core_s;
   logic arm0, arm1, lv0, lv1, off;

   // ------------------------------------------------------------
   // Register shadow
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 1'b0;
         pa <= 8'h00;
         sense_s <= 8'h00;
         en_s <= 8'h00;
         core_s <= 8'h00;
      end else begin
         ph <= hsel && hready && htrans[1] && hwrite;
         pa <= haddr[7:0];
         if (ph && pa == `EPI_OFS_SENSE) sense_s <= hwdata[7:0];
         if (ph && pa == `EPI_OFS_ENABLE) en_s <= hwdata[7:0];
         if (ph && pa == `EPI_OFS_CORE) core_s <= hwdata[7:0];
      end
   end

   assign arm0 = core_s[7] && !core_s[0] && en_s[6];
   assign arm1 = core_s[7] && !core_s[0] && en_s[7];
   assign lv0 = arm0 && sense_s[1:0] == `EPI_MODE_LOW && !ext_irq_pin_zero;
   assign lv1 = arm1 && sense_s[3:2] == `EPI_MODE_LOW && !ext_irq_pin_one;
   assign off = !core_s[7] || en_s[7:5] == 3'b000;

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_fall0;
      arm0 && sense_s[1:0] == `EPI_MODE_FALL && $fell(ext_irq_pin_zero);
   endsequence
   sequence s_rise1;
      arm1 && sense_s[3:2] == `EPI_MODE_RISE && $rose(ext_irq_pin_one);
   endsequence
   sequence s_any0;
      arm0 && sense_s[1:0] == `EPI_MODE_ANY && $changed(ext_irq_pin_zero);
   endsequence

   property p_gate;
      off [*2] |-> !irq_req;
   endproperty
   property p_lv0;
      lv0 [*5] |-> irq_req && irq_vector == 2'd0;
   endproperty
   property p_lv1;
      lv1 [*5] |-> irq_req;
   endproperty
   property p_fall0;
      s_fall0 |-> ##[1:8] irq_req;
   endproperty
   property p_rise1;
      s_rise1 |-> ##[1:8] irq_req;
   endproperty
   property p_any0;
      s_any0 |-> ##[1:8] irq_req;
   endproperty
   property p_pulse;
      wake_req |=> !wake_req;
   endproperty
   property p_wake;
      wake_req |-> core_s[0];
   endproperty

   a_gate: assert property (p_gate) else $error("request while disabled");
   a_lv0: assert property (p_lv0) else $error("pin zero level lost");
   a_lv1: assert property (p_lv1) else $error("pin one level lost");
   a_fall0: assert property (p_fall0) else $error("pin zero fall missed");
   a_rise1: assert property (p_rise1) else $error("pin one rise missed");
   a_any0: assert property (p_any0) else $error("pin zero change missed");
   a_pulse: assert property (p_pulse) else $error("wake longer than one cycle");
   a_wake: assert property (p_wake) else $error("wake while awake");
endmodule

bind epi_top epi_top_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin_zero(ext_irq_pin_zero),
   .ext_irq_pin_one(ext_irq_pin_one), .ext_irq_pin_two(ext_irq_pin_two),
   .vector_ack(vector_ack), .vector_ack_id(vector_ack_id), .irq_req(irq_req),
   .irq_vector(irq_vector), .wake_req(wake_req)
);

// ===== test/tb_epi_top.sv
// Purpose: Register-level test of the pin interrupt block
// Assumes: Zero-wait slave; flags settle within ten cycles of a pin edge
// Notes: The start-up count is shortened to keep the run brief
`timescale 1ns/1ps
`include "epi_defs.vh"
module tb_epi_top;
   logic hclk, hresetn, hwrite, vector_ack, hreadyout, hresp, irq_req, wake_req;
   logic [1:0] htrans, vector_ack_id, irq_vector;
   logic [2:0] hsize, pins;
   logic [31:0] haddr, hwdata, hrdata, rv;
   int n_errors = 0;
   int n_compared = 0;
   int m, p;

   epi_top #(.STARTUP_CYCLES(8)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ext_irq_pin_zero(pins[0]), .ext_irq_pin_one(pins[1]), .ext_irq_pin_two(pins[2]),
      .vector_ack(vector_ack), .vector_ack_id(vector_ack_id), .irq_req(irq_req),
      .irq_vector(irq_vector), .wake_req(wake_req)
   );
   epi_pin_src i_src (.hclk(hclk), .pins(pins));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Bounded wait for the slave to answer
   task automatic hwait();
      int n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            n_errors++;
            end_of_test();
         end
         @(posedge hclk);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      hwait();
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      hwait();
      rv = hrdata;
   endtask

   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, e, rv);
      chk("hresp", 32'h0, hresp);
   endtask

   function automatic logic [31:0] fb(input int q);
      return 32'h0000_0001 << (q ? `EPI_PIN_ONE_BIT : `EPI_PIN_ZERO_BIT);
   endfunction

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      vector_ack = 1'b0;
      vector_ack_id = 2'b00;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc("sense_reset", `EPI_OFS_SENSE, 32'h0000_0000);
      bus(1'b1, 8'h1C, 8'hFF);
      rc("unmapped", 8'h1C, 32'h0000_0000);
      bus(1'b1, `EPI_OFS_PINDIR, 8'hFF);
      bus(1'b1, `EPI_OFS_ENABLE, 8'hE0);
      i_src.put(0, 1'b0);
      cyc(10);
      chk("irq_no_global", 32'h0, irq_req);
      i_src.put(0, 1'b1);
      bus(1'b1, `EPI_OFS_CORE, 8'h80);
      for (p = 0; p < 2; p++) begin
         i_src.put(p, 1'b0);
         cyc(10);
         chk("irq_level", 32'h1, irq_req);
         chk("vector", p, irq_vector);
         rc("flags_level", `EPI_OFS_FLAGS, 32'h0000_0000);
         i_src.put(p, 1'b1);
         cyc(10);
         chk("irq_idle", 32'h0, irq_req);
      end
      for (p = 0; p < 2; p++) begin
         for (m = 1; m < 4; m++) begin
            bus(1'b1, `EPI_OFS_SENSE, 8'(m << (2 * p)));
            bus(1'b1, `EPI_OFS_FLAGS, 8'hE0);
            i_src.put(p, 1'b0);
            cyc(10);
            rc("flag_fall", `EPI_OFS_FLAGS, (m != 3) ? fb(p) : 32'h0);
            bus(1'b1, `EPI_OFS_FLAGS, 8'h00);
            rc("flag_write0", `EPI_OFS_FLAGS, (m != 3) ? fb(p) : 32'h0);
            bus(1'b1, `EPI_OFS_FLAGS, 8'hE0);
            i_src.put(p, 1'b1);
            cyc(10);
            rc("flag_rise", `EPI_OFS_FLAGS, (m != 2) ? fb(p) : 32'h0);
            bus(1'b1, `EPI_OFS_FLAGS, 8'hE0);
            rc("flag_w1c", `EPI_OFS_FLAGS, 32'h0000_0000);
         end
      end
      bus(1'b1, `EPI_OFS_SENSE, 8'h02);
      i_src.put(0, 1'b0);
      cyc(10);
      chk("irq_edge", 32'h1, irq_req);
      vector_ack_id <= 2'b00;
      vector_ack <= 1'b1;
      @(posedge hclk);
      vector_ack <= 1'b0;
      rc("flag_vector", `EPI_OFS_FLAGS, 32'h0000_0000);
      i_src.put(0, 1'b1);
      for (m = 0; m < 2; m++) begin
         bus(1'b1, `EPI_OFS_ENABLE, 8'hC0);
         bus(1'b1, `EPI_OFS_CSR, 8'(m << `EPI_SENSE_TWO_BIT));
         cyc(10);
         bus(1'b1, `EPI_OFS_FLAGS, 8'hE0);
         bus(1'b1, `EPI_OFS_ENABLE, 8'hE0);
         repeat (2) begin
            i_src.put(2, ~pins[2]);
            cyc(10);
            rc("flag_two", `EPI_OFS_FLAGS, (pins[2] == m) ? 32'h20 : 32'h0);
            bus(1'b1, `EPI_OFS_FLAGS, 8'hE0);
         end
      end
      i_src.pulse2();
      cyc(10);
      rc("flag_pulse", `EPI_OFS_FLAGS, 32'h0000_0020);
      bus(1'b1, `EPI_OFS_FLAGS, 8'hE0);
      bus(1'b1, `EPI_OFS_SENSE, 8'h02);
      bus(1'b1, `EPI_OFS_CORE, 8'h81);
      i_src.put(0, 1'b0);
      cyc(10);
      rc("flag_sleep", `EPI_OFS_FLAGS, 32'h0000_0000);
      i_src.put(0, 1'b1);
      bus(1'b1, `EPI_OFS_CSR, 8'h00);
      bus(1'b1, `EPI_OFS_ENABLE, 8'hC0);
      cyc(10);
      rc("flag_buffer", `EPI_OFS_FLAGS, 32'h0000_0020);
      bus(1'b1, `EPI_OFS_FLAGS, 8'hE0);
      bus(1'b1, `EPI_OFS_ENABLE, 8'hE0);
      bus(1'b1, `EPI_OFS_SENSE, 8'h00);
      i_src.put(0, 1'b0);
      m = 0;
      while (wake_req !== 1'b1 && m < 400) begin
         @(posedge hclk);
         m++;
      end
      chk("wake", 32'h1, wake_req);
      i_src.put(0, 1'b1);
      i_src.put(0, 1'b0);
      cyc(3);
      chk("irq_after_lost_level", 32'h0, irq_req);
      i_src.put(0, 1'b1);
      bus(1'b1, `EPI_OFS_CORE, 8'h80);
      end_of_test();
   end
endmodule
